// [hdl/scwd_pkg.sv]
/*
 * Constants for the synthesizer control-word decoder: control codes, field positions and widths,
 * lock-detect counts and window times.
 * Assumes a 40 MHz system clock. Serial pins are treated as synchronous to it.
 */
package scwd_pkg;

    // ==========================================================================
    // word and control codes
    // ==========================================================================
    localparam int unsigned WORD_BITS   = 32;
    localparam logic [2:0]  CTL_INT_FRACTION_NUMERATOR = 3'h0;
    localparam logic [2:0]  CTL_PH_MOD   = 3'h1;
    localparam logic [2:0]  CTL_REF_LOOP = 3'h2;
    localparam logic [2:0]  CTL_CLK_DIV  = 3'h3;

    // ==========================================================================
    // integer / fraction word
    // ==========================================================================
    localparam int unsigned INT_LSB  = 15;
    localparam int unsigned INT_W    = 16;
    localparam int unsigned FRACTION_NUMERATOR_LSB = 3;
    localparam int unsigned FRACTION_NUMERATOR_W   = 12;

    // ==========================================================================
    // phase / prescaler / modulus word
    // ==========================================================================
    localparam int unsigned PH_ADJ_BIT = 28;
    localparam int unsigned PRESC_BIT  = 27;
    localparam int unsigned PHASE_LSB  = 15;
    localparam int unsigned PHASE_W    = 12;
    localparam int unsigned MOD_LSB    = 3;
    localparam int unsigned MOD_W      = 12;
    localparam int unsigned INT_MIN_45 = 23;
    localparam int unsigned INT_MIN_89 = 75;

    // ==========================================================================
    // reference and loop control word
    // ==========================================================================
    localparam int unsigned NOISE_LSB   = 29;
    localparam int unsigned MON_LSB     = 26;
    localparam int unsigned MON_W       = 3;
    localparam int unsigned DOUBLER_BIT = 25;
    localparam int unsigned HALVER_BIT  = 24;
    localparam int unsigned RCNT_LSB    = 14;
    localparam int unsigned RCNT_W      = 10;
    localparam int unsigned CP_LSB      = 9;
    localparam int unsigned CP_W        = 4;
    localparam int unsigned LDF_BIT     = 8;
    localparam int unsigned LDP_BIT     = 7;
    localparam int unsigned POL_BIT     = 6;
    localparam int unsigned PDN_BIT     = 5;
    localparam int unsigned CP3S_BIT    = 4;
    localparam int unsigned CRST_BIT    = 3;
    localparam logic [1:0]  NOISE_LOW_NOISE = 2'h0;
    localparam logic [1:0]  NOISE_LOW_SPUR  = 2'h3;

    // ==========================================================================
    // clock divider word
    // ==========================================================================
    localparam int unsigned ABP_BIT    = 22;
    localparam int unsigned CDM_LSB    = 15;
    localparam logic [1:0]  CDM_OFF    = 2'h0;
    localparam logic [1:0]  CDM_FAST   = 2'h1;
    localparam logic [1:0]  CDM_RESYNC = 2'h2;

    // ==========================================================================
    // lock detect
    // ==========================================================================
    localparam int unsigned LD_COUNT_FRACTION_NUMERATOR = 40;
    localparam int unsigned LD_COUNT_INT  = 5;
    localparam int unsigned LD_WIN_WIDE_NS   = 10;
    localparam int unsigned LD_WIN_NARROW_NS = 6;
    localparam int unsigned ABP_LONG_NS  = 6;
    localparam int unsigned ABP_SHORT_NS = 3;
    localparam int unsigned CLK_PERIOD_PS = 25000;
    // each window rounds down, at least one cycle
    localparam int unsigned LD_WIN_WIDE_CYC   = (LD_WIN_WIDE_NS * 1000 / CLK_PERIOD_PS) < 1 ? 1 :
                                                (LD_WIN_WIDE_NS * 1000 / CLK_PERIOD_PS);
    localparam int unsigned LD_WIN_NARROW_CYC = (LD_WIN_NARROW_NS * 1000 / CLK_PERIOD_PS) < 1 ? 1 :
                                                (LD_WIN_NARROW_NS * 1000 / CLK_PERIOD_PS);

endpackage : scwd_pkg

// [hdl/scwd_ref_counter.sv]
/*
 * Reference path divider: divides the reference edge pulses by a programmable count and
 * optionally halves the result through a toggle stage.
 * Assumes ref_edge is a single-cycle pulse per active reference edge.
 */
`timescale 1ns/1ps

module scwd_ref_counter #(
    parameter int unsigned CNT_W = 10
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             hold,
    input  wire logic [CNT_W-1:0] divide,
    input  wire logic             halve,
    input  wire logic             ref_edge,
    output logic                  pfd_tick
);

    initial
    begin
        if (CNT_W < 1 || CNT_W > 16)
            $error("scwd_ref_counter: CNT_W out of range");
    end

    logic [CNT_W-1:0] count;
    logic             toggle;
    logic             wrap;
    logic [CNT_W-1:0] div_eff;

    // divide value zero is not legal; serve it as one
    assign div_eff = (divide == '0) ? CNT_W'(1) : divide;
    assign wrap    = ref_edge && (count >= div_eff - CNT_W'(1));

    // ==========================================================================
    // counter
    // ==========================================================================
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            count <= '0;
        else if (hold)
            count <= '0;
        else if (wrap)
            count <= '0;
        else if (ref_edge)
            count <= count + CNT_W'(1);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            toggle <= 1'b0;
        else if (hold)
            toggle <= 1'b0;
        else if (wrap)
            toggle <= ~toggle;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            pfd_tick <= 1'b0;
        else
            pfd_tick <= wrap && !hold && (!halve || toggle);
    end

endmodule : scwd_ref_counter

// [hdl/scwd_top.sv]
/*
 * Control-word decoder for a fractional-N synthesizer: three-wire serial load, word routing,
 * double-buffered fields, reference path, lock detect and power-down effects.
 * Assumes serial pins and reference are synchronous to clk; analog parts sit outside.
 */
`timescale 1ns/1ps

module scwd_top #(
    parameter int unsigned RCNT_W = scwd_pkg::RCNT_W
) (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        ser_clk,
    input  wire logic        ser_data,
    input  wire logic        ser_le,
    input  wire logic        reference_input_pin,
    input  wire logic        pfd_phase_err_valid,
    input  wire logic [7:0]  pfd_phase_err_cyc,
    output logic [15:0]      integer_value,
    output logic [11:0]      fraction_numerator,
    output logic [11:0]      fraction_denominator,
    output logic [11:0]      phase_value,
    output logic             prescaler_select,
    output logic             phase_adjust,
    output logic             resync_request,
    output logic             dither_enable,
    output logic [1:0]       noise_mode,
    output logic [2:0]       monitor_output_select,
    output logic             reference_halver,
    output logic             doubler_enable,
    output logic [3:0]       cp_current,
    output logic             lock_detect_function,
    output logic             lock_detect_precision,
    output logic             pd_polarity,
    output logic             software_power_down,
    output logic             cp_tristate,
    output logic             counters_hold,
    output logic             rf_out_enable,
    output logic             pfd_tick,
    output logic [1:0]       clkdiv_mode,
    output logic             abp_short,
    output logic             digital_lock
);

    initial
    begin
        if (RCNT_W != scwd_pkg::RCNT_W)
            $error("scwd_top: RCNT_W must match the word field width");
    end

    // ==========================================================================
    // reset release
    // ==========================================================================
    logic [1:0] rst_sync;
    logic       rst_n;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            rst_sync <= 2'h0;
        else
            rst_sync <= {rst_sync[0], 1'b1};
    end
    assign rst_n = rst_sync[1];

    // ==========================================================================
    // serial shift and load strobe
    // ==========================================================================
    logic [31:0] shift_reg;
    logic        ser_clk_q;
    logic        ser_le_q;
    logic        load_pulse;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ser_clk_q <= 1'b0;
            ser_le_q  <= 1'b0;
        end
        else
        begin
            ser_clk_q <= ser_clk;
            ser_le_q  <= ser_le;
        end
    end

    // serial path stays live in power-down so a wake-up word can arrive
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            shift_reg <= 32'h0;
        else if (ser_clk && !ser_clk_q)
            shift_reg <= {shift_reg[30:0], ser_data};
    end

    assign load_pulse = ser_le && !ser_le_q;

    logic wr_int_fraction_numerator;
    logic wr_ph_mod;
    logic wr_ref_loop;
    logic wr_clk_div;

    // other control codes belong to other blocks and match nothing here
    assign wr_int_fraction_numerator = load_pulse && (shift_reg[2:0] == scwd_pkg::CTL_INT_FRACTION_NUMERATOR);
    assign wr_ph_mod   = load_pulse && (shift_reg[2:0] == scwd_pkg::CTL_PH_MOD);
    assign wr_ref_loop = load_pulse && (shift_reg[2:0] == scwd_pkg::CTL_REF_LOOP);
    assign wr_clk_div  = load_pulse && (shift_reg[2:0] == scwd_pkg::CTL_CLK_DIV);

    // ==========================================================================
    // shadow fields waiting for the integer/fraction write, and immediate prescaler/phase adjust bits
    // ==========================================================================
    logic [11:0]       sh_phase;
    logic [11:0]       sh_mod;
    logic [RCNT_W-1:0] sh_rcnt;
    logic              sh_doubler;
    logic              sh_halver;
    logic [3:0]        sh_cp;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sh_phase <= 12'h0;
            sh_mod   <= 12'h0;
        end
        else if (wr_ph_mod)
        begin
            sh_phase <= shift_reg[scwd_pkg::PHASE_LSB +: scwd_pkg::PHASE_W];
            sh_mod   <= shift_reg[scwd_pkg::MOD_LSB +: scwd_pkg::MOD_W];
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prescaler_select <= 1'b0;
            phase_adjust     <= 1'b0;
        end
        else if (wr_ph_mod)
        begin
            prescaler_select <= shift_reg[scwd_pkg::PRESC_BIT];
            phase_adjust     <= shift_reg[scwd_pkg::PH_ADJ_BIT];
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sh_rcnt    <= '0;
            sh_doubler <= 1'b0;
            sh_halver  <= 1'b0;
            sh_cp      <= 4'h0;
        end
        else if (wr_ref_loop)
        begin
            sh_rcnt    <= shift_reg[scwd_pkg::RCNT_LSB +: RCNT_W];
            sh_doubler <= shift_reg[scwd_pkg::DOUBLER_BIT];
            sh_halver  <= shift_reg[scwd_pkg::HALVER_BIT];
            sh_cp      <= shift_reg[scwd_pkg::CP_LSB +: scwd_pkg::CP_W];
        end
    end

    // ==========================================================================
    // immediate reference/loop fields
    // ==========================================================================
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            noise_mode            <= 2'h0;
            monitor_output_select <= 3'h0;
            lock_detect_function  <= 1'b0;
            lock_detect_precision <= 1'b0;
            pd_polarity           <= 1'b0;
            software_power_down   <= 1'b0;
            cp_tristate           <= 1'b0;
            counters_hold         <= 1'b0;
        end
        else if (wr_ref_loop)
        begin
            noise_mode            <= shift_reg[scwd_pkg::NOISE_LSB +: 2];
            monitor_output_select <= shift_reg[scwd_pkg::MON_LSB +: scwd_pkg::MON_W];
            lock_detect_function  <= shift_reg[scwd_pkg::LDF_BIT];
            lock_detect_precision <= shift_reg[scwd_pkg::LDP_BIT];
            pd_polarity           <= shift_reg[scwd_pkg::POL_BIT];
            software_power_down   <= shift_reg[scwd_pkg::PDN_BIT];
            cp_tristate           <= shift_reg[scwd_pkg::CP3S_BIT];
            counters_hold         <= shift_reg[scwd_pkg::CRST_BIT];
        end
    end

    assign dither_enable = (noise_mode == scwd_pkg::NOISE_LOW_SPUR);
    assign rf_out_enable = !software_power_down;

    // ==========================================================================
    // clock divider word
    // ==========================================================================
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            clkdiv_mode <= scwd_pkg::CDM_OFF;
            abp_short   <= 1'b0;
        end
        else if (wr_clk_div)
        begin
            clkdiv_mode <= shift_reg[scwd_pkg::CDM_LSB +: 2];
            abp_short   <= shift_reg[scwd_pkg::ABP_BIT];
        end
    end

    // ==========================================================================
    // integer/fraction write: live fields and buffered transfer
    // ==========================================================================
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            integer_value        <= 16'h0;
            fraction_numerator   <= 12'h0;
            fraction_denominator <= 12'h0;
            phase_value          <= 12'h0;
            reference_halver     <= 1'b0;
            doubler_enable       <= 1'b0;
            cp_current           <= 4'h0;
        end
        else if (wr_int_fraction_numerator)
        begin
            integer_value        <= shift_reg[scwd_pkg::INT_LSB +: scwd_pkg::INT_W];
            fraction_numerator   <= shift_reg[scwd_pkg::FRACTION_NUMERATOR_LSB +: scwd_pkg::FRACTION_NUMERATOR_W];
            fraction_denominator <= sh_mod;
            phase_value          <= sh_phase;
            reference_halver     <= sh_halver;
            doubler_enable       <= sh_doubler;
            cp_current           <= sh_cp;
        end
    end

    logic [RCNT_W-1:0] rcnt_live;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rcnt_live <= '0;
        else if (wr_int_fraction_numerator)
            rcnt_live <= sh_rcnt;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            resync_request <= 1'b0;
        else
            resync_request <= wr_int_fraction_numerator && !phase_adjust &&
                              (clkdiv_mode == scwd_pkg::CDM_RESYNC);
    end

    // ==========================================================================
    // reference edge selection and counter
    // ==========================================================================
    logic ref_q;
    logic ref_edge;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            ref_q <= 1'b0;
        else
            ref_q <= reference_input_pin;
    end

    assign ref_edge = doubler_enable ? (ref_q != reference_input_pin)
                                     : (ref_q && !reference_input_pin);

    scwd_ref_counter #(
        .CNT_W    (RCNT_W)
    ) u_ref_counter (
        .clk      (clk),
        .rst_n    (rst_n),
        .hold     (counters_hold || software_power_down),
        .divide   (rcnt_live),
        .halve    (reference_halver),
        .ref_edge (ref_edge),
        .pfd_tick (pfd_tick)
    );

    // ==========================================================================
    // digital lock detect
    // ==========================================================================
    logic [5:0] ld_count;
    logic [7:0] ld_window;
    logic [5:0] ld_target;
    logic       ld_in_win;

    assign ld_window = lock_detect_precision ? 8'(scwd_pkg::LD_WIN_NARROW_CYC)
                                             : 8'(scwd_pkg::LD_WIN_WIDE_CYC);
    assign ld_target = lock_detect_function ? 6'(scwd_pkg::LD_COUNT_INT)
                                            : 6'(scwd_pkg::LD_COUNT_FRACTION_NUMERATOR);
    // a 40 MHz clock cannot resolve 10 ns; both windows collapse to one cycle
    assign ld_in_win = pfd_phase_err_cyc < ld_window;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            ld_count <= 6'h0;
        else if (software_power_down || counters_hold)
            ld_count <= 6'h0;
        else if (pfd_phase_err_valid)
        begin
            if (!ld_in_win)
                ld_count <= 6'h0;
            else if (ld_count < ld_target)
                ld_count <= ld_count + 6'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            digital_lock <= 1'b0;
        else
            digital_lock <= !software_power_down && (ld_count >= ld_target);
    end

endmodule : scwd_top

// [testbench/scwd_host_model.sv]
/* Host model for the three-wire serial load: shifts 32-bit words msb first, then pulses load enable.
 * Assumes each call starts 1 ns after a clk rising edge. */
`timescale 1ns/1ps
module scwd_host_model (
    input  wire logic clk,
    output logic      ser_clk,
    output logic      ser_data,
    output logic      ser_le
);
    // ====================
    // word transfer
    initial
    begin
        ser_clk  = 1'b0;
        ser_data = 1'b0;
        ser_le   = 1'b0;
    end
    task automatic send(input logic [31:0] w);
        for (int i = 31; i >= 0; i--)
        begin
            ser_clk  = 1'b0;
            ser_data = w[i];
            @(posedge clk);
            #1 ser_clk = 1'b1;
            @(posedge clk);
            #1;
        end
        // link clock stands low between words; data leaves no stale level behind
        ser_clk  = 1'b0;
        ser_data = ~w[0];
        ser_le   = 1'b1;
        @(posedge clk);
        #1 ser_le = 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask : send
endmodule : scwd_host_model

// [testbench/scwd_props.sv]
/* Port checker for scwd_top: causes and timing of derived outputs, resync and lock.
 * Assumes one clock domain and the bind at the foot of this file. */
`timescale 1ns/1ps
module scwd_props (
    input wire logic       clk,
    input wire logic       nrst,
    input wire logic       ser_le,
    input wire logic       pfd_phase_err_valid,
    input wire logic [7:0] pfd_phase_err_cyc,
    input wire logic [1:0] noise_mode,
    input wire logic [2:0] monitor_output_select,
    input wire logic [3:0] cp_current,
    input wire logic       phase_adjust,
    input wire logic       resync_request,
    input wire logic       dither_enable,
    input wire logic       software_power_down,
    input wire logic       counters_hold,
    input wire logic       rf_out_enable,
    input wire logic       pfd_tick,
    input wire logic [1:0] clkdiv_mode,
    input wire logic       digital_lock
);
    // ====================
    // assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    AST_RF_OUT: assert property (rf_out_enable == !software_power_down)
        else $error("output enable disagrees with power down");
    AST_DITHER: assert property (dither_enable == (noise_mode == 2'h3))
        else $error("dither not tied to lowest spur mode");
    AST_LOAD_NOW: assert property ($changed(monitor_output_select) |-> $past(ser_le))
        else $error("monitor select changed without a load");
    AST_LOAD_BUF: assert property ($changed(cp_current) |-> $past(ser_le) || $past(ser_le, 2))
        else $error("pump current changed without a load");
    AST_RESYNC_CAUSE: assert property (resync_request |-> !phase_adjust && clkdiv_mode == 2'h2)
        else $error("resync without resync mode");
    AST_RESYNC_PULSE: assert property (resync_request |=> !resync_request)
        else $error("resync longer than one cycle");
    // the count lands one edge after the comparison and the lock flag one edge later
    AST_LOCK_CAUSE: assert property ($rose(digital_lock) |-> $past(pfd_phase_err_valid, 2))
        else $error("lock rose without a comparison");
    AST_LOCK_DROP: assert property (pfd_phase_err_valid && pfd_phase_err_cyc != 8'h00 |-> ##2 !digital_lock)
        else $error("lock kept after out of window");
    AST_PD_CLEARS: assert property (software_power_down |=> !digital_lock)
        else $error("lock kept in power down");
    AST_HOLD_QUIET: assert property ((software_power_down || counters_hold) [*3] |-> !pfd_tick)
        else $error("tick while counters held");
endmodule : scwd_props
bind scwd_top scwd_props scwd_props_inst (.*);

// [testbench/tb_top.sv]
/* Self-checking bench for scwd_top: word table, then refused codes, resync, reference path, lock.
 * Assumes scwd_host_model drives the serial pins. */
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin fail_count++; \
    $display("MISMATCH t=%0t got %0h exp %0h", $time, a, e); end end
module tb_top;
    typedef struct packed {logic [31:0] w; logic [31:0] e;} scwd_row_t;
    localparam logic [31:0] W0 = 32'h091A_07F8;
    logic clk, nrst, ser_clk, ser_data, ser_le, reference_input_pin, pfd_phase_err_valid;
    logic [7:0] pfd_phase_err_cyc;
    logic [15:0] integer_value;
    logic [11:0] fraction_numerator, fraction_denominator, phase_value;
    logic [3:0] cp_current;
    logic [2:0] monitor_output_select;
    logic [1:0] noise_mode, clkdiv_mode;
    logic prescaler_select, phase_adjust, resync_request, dither_enable, reference_halver, doubler_enable;
    logic lock_detect_function, lock_detect_precision, pd_polarity, software_power_down, cp_tristate;
    logic counters_hold, rf_out_enable, pfd_tick, abp_short, digital_lock;
    int fail_count, samples_checked, cycles, ticks, resync_seen;
    scwd_row_t rows [5] = '{
        '{32'h7600_D552, 32'h7600_1552},
        '{32'h0900_4A82, 32'h0900_0A82},
        '{32'h1891_A2B1, 32'h1891_A2B1},
        '{32'h0041_55E3, 32'h0041_0003},
        '{W0, W0}};
    scwd_top scwd_top_inst (.*);
    scwd_host_model scwd_host_model_inst (.*);
    // ====================
    // helpers
    function automatic logic [31:0] img(input logic [2:0] c);
        case (c)
            3'h0: img = {1'b0, integer_value, fraction_numerator, 3'h0};
            3'h1: img = {3'h0, phase_adjust, prescaler_select, phase_value, fraction_denominator, 3'h1};
            3'h2: img = {1'b0, noise_mode, monitor_output_select, doubler_enable, reference_halver, 11'h0,
                         cp_current, lock_detect_function, lock_detect_precision, pd_polarity,
                         software_power_down, cp_tristate, counters_hold, 3'h2};
            default: img = {9'h0, abp_short, 5'h0, clkdiv_mode, 12'h0, 3'h3};
        endcase
    endfunction : img
    task automatic send(input logic [31:0] w);
        scwd_host_model_inst.send(w);
    endtask : send
    // equal gaps keep every comparison at one cycle per pulse
    task automatic lockrun(input int n, input logic [7:0] err);
        repeat (n)
        begin
            pfd_phase_err_valid = 1'b1;
            pfd_phase_err_cyc   = err;
            @(posedge clk);
            #1 pfd_phase_err_valid = 1'b0;
            @(posedge clk);
            #1;
        end
    endtask : lockrun
    task automatic refrun(input int n);
        ticks = 0;
        repeat (n)
        begin
            repeat (4) @(posedge clk);
            #1 reference_input_pin = ~reference_input_pin;
        end
        repeat (8) @(posedge clk);
        #1;
    endtask : refrun
    task automatic final_report;
        if (fail_count == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : final_report
    // ====================
    // clock, monitors, timeout
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cycles++;
        if (pfd_tick === 1'b1) ticks++;
        if (resync_request === 1'b1) resync_seen++;
        if (cycles == 20000)
        begin
            fail_count++;
            final_report();
        end
    end
    // ====================
    // main sequence
    initial
    begin
        nrst = 1'b0;
        reference_input_pin = 1'b0;
        pfd_phase_err_valid = 1'b0;
        pfd_phase_err_cyc = 8'h00;
        repeat (4) @(posedge clk);
        `CHK(rf_out_enable, 1'b1)
        `CHK(img(3'h0), 32'h0)
        #1 nrst = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        foreach (rows[i])
        begin
            send(rows[i].w);
            send(W0);
            `CHK(img(rows[i].w[2:0]), rows[i].e)
        end
        send(32'hFFFF_FFFC);
        send(32'hFFFF_FFFD);
        `CHK(img(3'h2), 32'h0900_0A82)
        `CHK(img(3'h0), W0)
        send(32'h0091_A2B1);
        send(W0);
        `CHK(resync_seen, 1)
        refrun(80);
        `CHK(ticks, 20)
        send(32'h0200_4A82);
        send(W0);
        refrun(20);
        `CHK(ticks, 20)
        lockrun(1, 8'h01);
        lockrun(39, 8'h00);
        `CHK(digital_lock, 1'b0)
        lockrun(1, 8'h00);
        `CHK(digital_lock, 1'b1)
        lockrun(1, 8'h01);
        `CHK(digital_lock, 1'b0)
        send(32'h0200_4B82);
        lockrun(4, 8'h00);
        `CHK(digital_lock, 1'b0)
        lockrun(1, 8'h00);
        `CHK(digital_lock, 1'b1)
        send(32'h0200_4BAA);
        refrun(8);
        `CHK({digital_lock, rf_out_enable, counters_hold, ticks == 0}, 4'h3)
        `CHK(img(3'h0), W0)
        // serial path must keep loading while powered down; mode off leaves no resync to request
        send(32'h0000_0003);
        send(32'h0000_A2B1);
        send(W0);
        `CHK(img(3'h1), 32'h0000_A2B1)
        `CHK(img(3'h3), 32'h0000_0003)
        `CHK(resync_seen, 2)
        final_report();
    end
endmodule : tb_top
